// file: hdl/xfer_regs_pkg.sv
// constants and carrier types for the mapped transfer address register section
package xfer_regs_pkg;
    // upper select codes, bits 9:8 of the register select
    localparam logic [1:0] SEL_CTRL_PATH = 2'h0;
    localparam logic [1:0] SEL_INTERNAL  = 2'h1;
    localparam logic [1:0] SEL_MAP       = 2'h2;
    // low select codes within the internal group
    localparam logic [2:0] REG_CONFIG    = 3'h0;
    localparam logic [2:0] REG_CONTROL   = 3'h1;
    localparam logic [2:0] REG_STATUS    = 3'h2;
    localparam logic [2:0] REG_VADDR     = 3'h3;
    localparam logic [2:0] REG_BYTECNT   = 3'h4;
    localparam logic [2:0] REG_DIAG      = 3'h5;
    // output mux select codes
    localparam logic [2:0] MUX_CONFIG    = 3'h0;
    localparam logic [2:0] MUX_CONTROL   = 3'h1;
    localparam logic [2:0] MUX_STATUS    = 3'h2;
    localparam logic [2:0] MUX_VADDR     = 3'h3;
    localparam logic [2:0] MUX_BYTECNT   = 3'h4;
    localparam logic [2:0] MUX_DIAG      = 3'h5;
    localparam logic [2:0] MUX_MAP       = 3'h6;
    localparam logic [2:0] MUX_CMD_ADDR  = 3'h7;
    // tag and mask codes seen on the backplane
    localparam logic [2:0] TAG_READ_DATA = 3'h0;
    localparam logic [3:0] MASK_NORMAL   = 4'h0;
    localparam logic [3:0] MASK_CORRECT  = 4'h1;
    localparam logic [3:0] MASK_SUBST    = 4'h2;
    // field positions
    localparam int          STAT_PGE_BIT  = 0;
    localparam int          CTRL_DIAG_EN  = 0;
    localparam int          MAP_ENTRIES   = 256;
    localparam logic [16:0] VADDR_RESET   = 17'h00000;
    localparam logic [31:0] BYTECNT_RESET = 32'h00000000;
    localparam logic [31:0] REG_RESET     = 32'h00000000;
    // command word fixed bits
    localparam logic [1:0]  CMD_TOP_BITS  = 2'h2;
    localparam logic [1:0]  FUNC_EXT_WR   = 2'h3;
    localparam logic [1:0]  FUNC_EXT_RD   = 2'h0;

    typedef enum logic [2:0] {
        RD_NONE    = 3'b001,
        RD_NORMAL  = 3'b010,
        RD_FLAGGED = 3'b100
    } rd_state_e;

    // command/address word received from the backplane
    typedef struct packed {
        logic [2:0] tag;
        logic [3:0] id;
        logic [3:0] mask;
        logic [9:0] sel;
    } rx_cmd_s;

    // read data class flags
    typedef struct packed {
        logic substitute;
        logic corrected;
        logic normal;
    } rd_class_s;
endpackage

// file: hdl/xfer_regs.sv
// register section: select decode, page map, virtual address, byte count, command word
// Behaviour
// - classify own read data by mask field
// - drive bus data or summary per enable
// - capture received information on T0 phase
// - upper select bits pick group, low pick register
// - write clock only with strobe and T2
// - only control, and diagnostic with control bit 0 set, accessible while busy
// - forbidden internal or map group write while busy sets error flag
// - map write while busy is dropped
// - virtual address counter loaded at start
// - page pointer steps at page crossing
// - quadword bits step on quadword done
// - low three bits select packing byte
// - map address from pointer when busy
// - 256 entries translate virtual to physical pages
// - idle map write stores data with parity
// - map readable when write enables idle
// - command request selects D7 mux input
// - device read issues extended write command
// - bit31 one, bit30 zero, function bits
// - page number from map entry bits
// - quadword address bits, bit zero zero
// - 32-bit byte counter tracks both sides
// - upper half storage, lower half backplane
module xfer_regs (
    input  wire logic                      clk,                   // 125 MHz clock
    input  wire logic                      arst_n,                // async reset, active low
    input  wire logic                      phase_t0,              // backplane phase T0
    input  wire logic                      phase_t2,              // backplane phase T2
    input  wire xfer_regs_pkg::rx_cmd_s    rx_cmd,                // received tag/id/mask/select
    input  wire logic [31:0]               rx_data,               // received data bits
    input  wire logic [3:0]                own_id,                // adapter identifier
    input  wire logic                      inbound_internal_latch_clock, // latch request
    input  wire logic                      register_write_strobe, // internal register strobe
    input  wire logic                      register_read,         // internal read request
    input  wire logic                      transfer_start,        // load virtual address
    input  wire logic                      transfer_busy,         // transfer in progress
    input  wire logic                      device_read_transfer,  // read from storage device
    input  wire logic                      cmd_request,           // memory command request
    input  wire logic                      quadword_done_step,    // quadword moved to memory
    input  wire logic                      page_cross,            // byte address crossed page
    input  wire logic                      bp_byte_step,          // backplane side byte moved
    input  wire logic                      st_byte_step,          // storage side byte moved
    input  wire logic [15:0]               interrupt_summary_response, // summary word
    input  wire logic                      internal_data_drive_enable, // drive bus data
    input  wire logic                      summary_data_drive_enable,  // drive summary data
    output logic [31:0]                    adapter_internal_bus,  // output mux result
    output logic [31:0]                    bp_data_out,           // backplane data
    output logic                           bp_data_oe,            // backplane data enable
    output xfer_regs_pkg::rd_class_s       rd_class,              // read data class
    output logic [2:0]                     pack_byte_sel,         // byte within quadword
    output logic [2:0]                     output_mux_select,     // mux select in use
    output logic                           map_write_enable_one,  // map write, lower half
    output logic                           map_write_enable_two,  // map write, upper half
    output logic                           programming_error_flag // status error flag
);
    logic       rst_sync1_q;
    logic       rst_sync2_q;
    wire  logic rst_n = rst_sync2_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end

    xfer_regs_pkg::rx_cmd_s rx_cmd_q;
    logic [31:0]            rx_data_q;
    wire  logic             rx_latch = inbound_internal_latch_clock & phase_t0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cmd_q  <= '0;
            rx_data_q <= xfer_regs_pkg::REG_RESET;
        end else if (rx_latch) begin
            rx_cmd_q  <= rx_cmd;
            rx_data_q <= rx_data;
        end
    end

    wire logic own_read = (rx_cmd_q.tag == xfer_regs_pkg::TAG_READ_DATA)
                          && (rx_cmd_q.id == own_id);
    xfer_regs_pkg::rd_state_e rd_d;
    xfer_regs_pkg::rd_state_e rd_q;
    always_comb begin
        rd_d = xfer_regs_pkg::RD_NONE;
        if (own_read) begin
            case (rx_cmd_q.mask)
                xfer_regs_pkg::MASK_NORMAL:  rd_d = xfer_regs_pkg::RD_NORMAL;
                xfer_regs_pkg::MASK_CORRECT: rd_d = xfer_regs_pkg::RD_FLAGGED;
                default:                     rd_d = xfer_regs_pkg::RD_FLAGGED;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q     <= xfer_regs_pkg::RD_NONE;
            rd_class <= '0;
        end else begin
            rd_q                <= rd_d;
            rd_class.normal     <= own_read && rx_cmd_q.mask == xfer_regs_pkg::MASK_NORMAL;
            rd_class.corrected  <= own_read && rx_cmd_q.mask == xfer_regs_pkg::MASK_CORRECT;
            rd_class.substitute <= own_read && rx_cmd_q.mask == xfer_regs_pkg::MASK_SUBST;
        end
    end

    wire logic [1:0] grp      = rx_cmd_q.sel[9:8];
    wire logic [2:0] low_sel  = rx_cmd_q.sel[2:0];
    wire logic       grp_int  = (grp == xfer_regs_pkg::SEL_INTERNAL);
    wire logic       grp_map  = (grp == xfer_regs_pkg::SEL_MAP);
    // write clock needs strobe and T2
    wire logic       wr_clk   = register_write_strobe & phase_t2;
    wire logic       is_ctrl  = grp_int && low_sel == xfer_regs_pkg::REG_CONTROL;
    wire logic       is_diag  = grp_int && low_sel == xfer_regs_pkg::REG_DIAG;
    logic [31:0]     ctrl_q;
    logic [31:0]     stat_q;
    logic [31:0]     diag_q;
    logic [31:0]     cfg_q;
    wire  logic      diag_en  = ctrl_q[xfer_regs_pkg::CTRL_DIAG_EN];
    wire logic       allowed  = !transfer_busy || is_ctrl || (is_diag && diag_en);
    wire logic       wr_ok    = wr_clk && allowed;
    wire logic       pge_set  = wr_clk && !allowed && (grp_int || grp_map);
    wire logic       wr_ctrl  = wr_ok && is_ctrl;
    wire logic       wr_diag  = wr_ok && is_diag;
    wire logic       wr_cfg   = wr_ok && grp_int && low_sel == xfer_regs_pkg::REG_CONFIG;
    wire logic       wr_stat  = wr_ok && grp_int && low_sel == xfer_regs_pkg::REG_STATUS;
    wire logic       wr_vaddr = wr_ok && grp_int && low_sel == xfer_regs_pkg::REG_VADDR;
    wire logic       wr_bcnt  = wr_ok && grp_int && low_sel == xfer_regs_pkg::REG_BYTECNT;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= xfer_regs_pkg::REG_RESET;
            diag_q <= xfer_regs_pkg::REG_RESET;
            cfg_q  <= xfer_regs_pkg::REG_RESET;
        end else begin
            if (wr_ctrl) ctrl_q <= rx_data_q;
            if (wr_diag) diag_q <= rx_data_q;
            if (wr_cfg)  cfg_q  <= rx_data_q;
        end
    end

    // status: write-one clears, but a new error wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= xfer_regs_pkg::REG_RESET;
        end else begin
            stat_q <= (wr_stat ? (stat_q & ~rx_data_q) : stat_q)
                      | {31'h0, pge_set};
        end
    end
    assign programming_error_flag = stat_q[xfer_regs_pkg::STAT_PGE_BIT];

    // virtual address counter, loaded at start or by register write
    logic [16:0] vaddr_q;
    logic [16:0] vaddr_d;
    always_comb begin
        vaddr_d = vaddr_q;
        if (transfer_start || wr_vaddr) begin
            vaddr_d = rx_data_q[16:0];
        end else begin
            if (quadword_done_step) vaddr_d[8:3] = vaddr_q[8:3] + 6'h01;
            if (page_cross) vaddr_d[16:9] = vaddr_q[16:9] + 8'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) vaddr_q <= xfer_regs_pkg::VADDR_RESET;
        else        vaddr_q <= vaddr_d;
    end
    assign pack_byte_sel = vaddr_q[2:0];

    // page map storage, 32 data bits plus parity
    logic [32:0] map_mem [xfer_regs_pkg::MAP_ENTRIES];
    wire logic [7:0] map_addr = transfer_busy ? vaddr_q[16:9] : rx_cmd_q.sel[7:0];
    wire logic       map_we   = wr_clk && grp_map && !transfer_busy;
    assign map_write_enable_one = map_we;
    assign map_write_enable_two = map_we;

    genvar gi;
    generate
        for (gi = 0; gi < xfer_regs_pkg::MAP_ENTRIES; gi++) begin : g_map
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    map_mem[gi] <= '0;
                end else if (map_we && map_addr == 8'(gi)) begin
                    map_mem[gi] <= {^rx_data_q, rx_data_q};
                end
            end
        end
    endgenerate
    wire logic [32:0] map_out = map_mem[map_addr];

    logic [31:0] bcnt_q;
    logic [31:0] bcnt_d;
    always_comb begin
        bcnt_d = bcnt_q;
        if (wr_bcnt) begin
            // backplane count copied into the storage half on write
            bcnt_d = {rx_data_q[15:0], rx_data_q[15:0]};
        end else begin
            // upper half storage, lower half backplane
            if (st_byte_step) bcnt_d[31:16] = bcnt_q[31:16] + 16'h0001;
            if (bp_byte_step) bcnt_d[15:0]  = bcnt_q[15:0] + 16'h0001;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) bcnt_q <= xfer_regs_pkg::BYTECNT_RESET;
        else        bcnt_q <= bcnt_d;
    end

    wire logic [1:0]  func    = device_read_transfer ? xfer_regs_pkg::FUNC_EXT_WR
                                                     : xfer_regs_pkg::FUNC_EXT_RD;
    wire logic [31:0] cmd_word = {xfer_regs_pkg::CMD_TOP_BITS, func, map_out[20:0],
                                  vaddr_q[8:3], 1'b0};

    wire logic [2:0] reg_mux  = grp_map ? xfer_regs_pkg::MUX_MAP : low_sel;
    assign output_mux_select  = cmd_request ? xfer_regs_pkg::MUX_CMD_ADDR : reg_mux;

    // blocked register reads while busy leave the bus holding its last value
    wire logic       rd_ok    = cmd_request || (register_read && allowed);
    logic [31:0]     mux_d;
    always_comb begin
        case (output_mux_select)
            xfer_regs_pkg::MUX_CONFIG:   mux_d = cfg_q;
            xfer_regs_pkg::MUX_CONTROL:  mux_d = ctrl_q;
            xfer_regs_pkg::MUX_STATUS:   mux_d = stat_q;
            xfer_regs_pkg::MUX_VADDR:    mux_d = {15'h0000, vaddr_q};
            xfer_regs_pkg::MUX_BYTECNT:  mux_d = bcnt_q;
            xfer_regs_pkg::MUX_DIAG:     mux_d = diag_q;
            xfer_regs_pkg::MUX_MAP:      mux_d = map_we ? 32'h00000000 : map_out[31:0];
            xfer_regs_pkg::MUX_CMD_ADDR: mux_d = cmd_word;
            default:                     mux_d = 32'h00000000;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)     adapter_internal_bus <= 32'h00000000;
        else if (rd_ok) adapter_internal_bus <= mux_d;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_data_out <= 32'h00000000;
            bp_data_oe  <= 1'b0;
        end else begin
            bp_data_oe  <= internal_data_drive_enable | summary_data_drive_enable;
            if (internal_data_drive_enable)
                bp_data_out <= adapter_internal_bus;
            else if (summary_data_drive_enable)
                bp_data_out <= {16'h0000, interrupt_summary_response};
        end
    end
endmodule

// file: verification/bp_phase_model.sv
// backplane phase generator standing in for the system bus cycle timing
module bp_phase_model (
    input  wire logic clk,      // system clock
    input  wire logic arst_n,   // async reset, active low
    output logic      phase_t0, // phase T0 marker
    output logic      phase_t2  // phase T2 marker
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) ph_q <= 2'h3;
        else ph_q <= ph_q + 2'h1;
    end
    assign phase_t0 = (ph_q == 2'h0);
    assign phase_t2 = (ph_q == 2'h2);
endmodule

// file: verification/xfer_regs_checker.sv
// port assertions for the mapped transfer register section
module xfer_regs_checker (
    input wire logic                     clk,                          // clock
    input wire logic                     arst_n,                       // reset
    input wire logic                     phase_t0,                     // T0
    input wire logic                     phase_t2,                     // T2
    input wire xfer_regs_pkg::rx_cmd_s   rx_cmd,                       // received fields
    input wire logic [3:0]               own_id,                       // adapter id
    input wire logic                     inbound_internal_latch_clock, // capture
    input wire logic                     register_write_strobe,        // write strobe
    input wire logic                     transfer_busy,                // busy
    input wire logic                     device_read_transfer,         // device read
    input wire logic                     cmd_request,                  // command request
    input wire logic [15:0]              interrupt_summary_response,   // summary word
    input wire logic                     internal_data_drive_enable,   // bus data enable
    input wire logic                     summary_data_drive_enable,    // summary enable
    input wire logic [31:0]              adapter_internal_bus,         // mux output
    input wire logic [31:0]              bp_data_out,                  // backplane data
    input wire logic                     bp_data_oe,                   // backplane enable
    input wire xfer_regs_pkg::rd_class_s rd_class,                     // read class
    input wire logic [2:0]               output_mux_select,            // mux select
    input wire logic                     map_write_enable_one,         // map write 1
    input wire logic                     map_write_enable_two,         // map write 2
    input wire logic                     programming_error_flag        // error flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire own_rd = inbound_internal_latch_clock && phase_t0 && rx_cmd.id == own_id
        && rx_cmd.tag == xfer_regs_pkg::TAG_READ_DATA;
    wire any_we = map_write_enable_one || map_write_enable_two;
    a_map_we_cause: assert property (any_we |-> register_write_strobe && phase_t2)
        else $error("map write outside strobe and T2");
    a_map_busy_block: assert property (transfer_busy |-> !any_we)
        else $error("map write while busy");
    a_cmd_mux_sel: assert property (cmd_request |-> output_mux_select == 3'h7)
        else $error("command request without mux input 7");
    a_cmd_fixed_bits: assert property (cmd_request |=>
        adapter_internal_bus[31:30] == 2'h2 && !adapter_internal_bus[0])
        else $error("command word fixed bits wrong");
    a_cmd_func_wr: assert property (cmd_request && device_read_transfer |=>
        adapter_internal_bus[29:28] == 2'h3) else $error("function not extended write");
    a_cmd_func_rd: assert property (cmd_request && !device_read_transfer |=>
        adapter_internal_bus[29:28] == 2'h0) else $error("function not extended read");
    a_drive_enable: assert property (##1 bp_data_oe ==
        $past(internal_data_drive_enable || summary_data_drive_enable))
        else $error("backplane enable does not follow its sources");
    a_summary_data: assert property (summary_data_drive_enable
        && !internal_data_drive_enable
        |=> bp_data_out[15:0] == $past(interrupt_summary_response))
        else $error("summary word not driven");
    a_class_subst: assert property (own_rd && rx_cmd.mask == xfer_regs_pkg::MASK_SUBST
        |-> ##2 rd_class == 3'h4) else $error("substitute class missing");
    a_class_normal: assert property (own_rd && rx_cmd.mask == xfer_regs_pkg::MASK_NORMAL
        |-> ##2 rd_class == 3'h1) else $error("normal class missing");
    a_error_cause: assert property ($rose(programming_error_flag) |->
        $past(transfer_busy && register_write_strobe && phase_t2))
        else $error("error flag set without busy write");
    c_cmd_dev_read: cover property (cmd_request && device_read_transfer);
    c_error_set: cover property ($rose(programming_error_flag));
    c_corrected: cover property (rd_class.corrected);
endmodule

bind xfer_regs xfer_regs_checker i_chk (.*);

// file: verification/xfer_regs_bench.sv
// self-checking bench for the mapped transfer register section
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module xfer_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] Z = 5'h00;
    localparam logic [9:0] S_VA = {xfer_regs_pkg::SEL_INTERNAL, Z, xfer_regs_pkg::REG_VADDR};
    localparam logic [9:0] S_BC = {xfer_regs_pkg::SEL_INTERNAL, Z, xfer_regs_pkg::REG_BYTECNT};
    localparam logic [9:0] S_CT = {xfer_regs_pkg::SEL_INTERNAL, Z, xfer_regs_pkg::REG_CONTROL};
    localparam logic [9:0] S_ST = {xfer_regs_pkg::SEL_INTERNAL, Z, xfer_regs_pkg::REG_STATUS};
    localparam logic [9:0] S_DG = {xfer_regs_pkg::SEL_INTERNAL, Z, xfer_regs_pkg::REG_DIAG};
    logic clk = 1'h0, arst_n = 1'h0, phase_t0, phase_t2;
    xfer_regs_pkg::rx_cmd_s rx_cmd = '0;
    logic [31:0] rx_data = 32'h0, adapter_internal_bus, bp_data_out;
    logic [3:0] own_id = 4'h3;
    logic [15:0] interrupt_summary_response = 16'h0;
    logic inbound_internal_latch_clock = 1'h0, register_write_strobe = 1'h0;
    logic register_read = 1'h0, transfer_start = 1'h0, transfer_busy = 1'h0;
    logic device_read_transfer = 1'h0, cmd_request = 1'h0, quadword_done_step = 1'h0;
    logic page_cross = 1'h0, bp_byte_step = 1'h0, st_byte_step = 1'h0;
    logic internal_data_drive_enable = 1'h0, summary_data_drive_enable = 1'h0;
    logic bp_data_oe, map_write_enable_one, map_write_enable_two, programming_error_flag;
    logic [2:0] pack_byte_sel, output_mux_select;
    xfer_regs_pkg::rd_class_s rd_class;
    int err_total = 0, compares = 0;
    xfer_regs i_dut (.*);
    bp_phase_model i_bp (.*);
    always #4 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge clk);
        s = 1'h0;
    endtask
    // words are taken only at T0, so wait for it before raising the latch request
    task automatic cap(input logic [2:0] tg, input logic [3:0] id, input logic [3:0] m,
                       input logic [9:0] sel, input logic [31:0] d);
        while (!phase_t0) @(negedge clk);
        rx_cmd = '{tg, id, m, sel};
        rx_data = d;
        inbound_internal_latch_clock = 1'h1;
        @(negedge clk);
        inbound_internal_latch_clock = 1'h0;
    endtask
    task automatic wr(input logic [9:0] sel, input logic [31:0] d);
        cap(3'h1, own_id, 4'h0, sel, d);
        while (!phase_t2) @(negedge clk);
        register_write_strobe = 1'h1;
        @(negedge clk);
        register_write_strobe = 1'h0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [9:0] sel, input logic [31:0] ex, input string nm);
        cap(3'h1, own_id, 4'h0, sel, 32'h0);
        register_read = 1'h1;
        @(negedge clk);
        `CHK(nm, ex, adapter_internal_bus)
        register_read = 1'h0;
    endtask
    task automatic t_vaddr();
        wr(S_VA, 32'h0001_2345);
        rd(S_VA, 32'h0001_2345, "vaddr");
        `CHK("pack_sel", 3'h5, pack_byte_sel)
        wr({xfer_regs_pkg::SEL_INTERNAL, Z, xfer_regs_pkg::REG_CONFIG}, 32'h5a5a_0f0f);
        rd({xfer_regs_pkg::SEL_INTERNAL, Z, xfer_regs_pkg::REG_CONFIG}, 32'h5a5a_0f0f,
           "config");
    endtask
    task automatic t_map();
        for (int i = 0; i < 256; i += 85) wr({2'h2, 8'(i)}, {8'(i), 8'h3c, ~8'(i), 8'hc3});
        for (int i = 0; i < 256; i += 85)
            rd({2'h2, 8'(i)}, {8'(i), 8'h3c, ~8'(i), 8'hc3}, "map");
    endtask
    task automatic t_cmd();
        wr({2'h2, 8'h12}, 32'h001a_bcde);
        wr({2'h2, 8'h13}, 32'h0012_3457);
        // virtual address taken from the received word at transfer start
        cap(3'h1, own_id, 4'h0, 10'h000, 32'h0000_2428);
        pulse(transfer_start);
        transfer_busy = 1'h1;
        device_read_transfer = 1'h1;
        cmd_request = 1'h1;
        cyc(2);
        `CHK("cmd_rd", {4'hb, 21'h1abcde, 6'h05, 1'h0}, adapter_internal_bus)
        `CHK("mux_sel", 3'h7, output_mux_select)
        device_read_transfer = 1'h0;
        cyc(2);
        `CHK("cmd_wr", {4'h8, 21'h1abcde, 6'h05, 1'h0}, adapter_internal_bus)
        pulse(quadword_done_step);
        cyc(2);
        `CHK("cmd_qw", {4'h8, 21'h1abcde, 6'h06, 1'h0}, adapter_internal_bus)
        pulse(page_cross);
        cyc(2);
        `CHK("cmd_pg", {4'h8, 21'h123457, 6'h06, 1'h0}, adapter_internal_bus)
        cmd_request = 1'h0;
    endtask
    task automatic t_busy();
        // a blocked read leaves the last command word on the bus
        rd(S_VA, {4'h8, 21'h123457, 6'h06, 1'h0}, "rd_blocked");
        wr(S_CT, 32'h0000_0001);
        `CHK("pge_ctrl", 1'h0, programming_error_flag)
        wr(S_DG, 32'h0000_0000);
        `CHK("pge_diag", 1'h0, programming_error_flag)
        wr(S_VA, 32'h0000_0000);
        `CHK("pge_vaddr", 1'h1, programming_error_flag)
        wr({2'h2, 8'h13}, 32'hffff_ffff);
        transfer_busy = 1'h0;
        rd({2'h2, 8'h13}, 32'h0012_3457, "map_kept");
        rd(S_VA, 32'h0000_2630, "vaddr_kept");
        wr(S_ST, 32'h0000_0001);
        `CHK("pge_clear", 1'h0, programming_error_flag)
    endtask
    task automatic t_class();
        for (int m = 0; m < 3; m++) begin
            cap(xfer_regs_pkg::TAG_READ_DATA, own_id, 4'(m), 10'h0, 32'h0);
            cyc(2);
            `CHK("rd_class", 3'(1 << m), rd_class)
        end
        cap(xfer_regs_pkg::TAG_READ_DATA, 4'hc, xfer_regs_pkg::MASK_SUBST, 10'h0, 32'h0);
        cyc(2);
        `CHK("rd_foreign", 3'h0, rd_class)
    endtask
    task automatic t_bytes();
        wr(S_BC, 32'h0000_0005);
        pulse(bp_byte_step);
        st_byte_step = 1'h1;
        cyc(2);
        st_byte_step = 1'h0;
        cyc(1);
        rd(S_BC, 32'h0007_0006, "bytecnt");
        internal_data_drive_enable = 1'h1;
        cyc(1);
        `CHK("bp_bus", 32'h0007_0006, bp_data_out)
        `CHK("bp_oe_on", 1'h1, bp_data_oe)
        internal_data_drive_enable = 1'h0;
        summary_data_drive_enable = 1'h1;
        interrupt_summary_response = 16'hbeef;
        cyc(1);
        `CHK("bp_sum", 16'hbeef, bp_data_out[15:0])
        summary_data_drive_enable = 1'h0;
        cyc(1);
        `CHK("bp_oe", 1'h0, bp_data_oe)
    endtask
    task automatic summarize();
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        cyc(3);
        arst_n = 1'h1;
        cyc(3);
        t_vaddr();
        t_map();
        t_cmd();
        t_busy();
        t_class();
        t_bytes();
        summarize();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule
